/* File: shared/acs_defs.svh */
// register offsets, field positions, reset values and timing for cipher control
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH
`define ACS_ADDR_STATUS     8'h82
`define ACS_ADDR_CTRL       8'h83
`define ACS_ADDR_BLOCK_LO   8'h84
`define ACS_ADDR_BLOCK_HI   8'h93
`define ACS_ADDR_ALIAS      8'h94
`define ACS_BIT_REQUEST     7
`define ACS_MODE_HI         6
`define ACS_MODE_LO         4
`define ACS_BIT_DIR         3
`define ACS_BIT_ERROR       7
`define ACS_BIT_DONE        0
`define ACS_CTRL_RESET      8'h00
`define ACS_RUN_TIME_US     24
`define ACS_CLK_MHZ         200
`define ACS_RUN_CYCLES      (`ACS_RUN_TIME_US * `ACS_CLK_MHZ)
`define ACS_BLOCK_BYTES     16
`endif

/* File: shared/acs_pkg.sv */
// types for the cipher control and status block
package acs_pkg;
  typedef enum logic [2:0] {
    ACS_MODE_ECB = 3'h0,
    ACS_MODE_KEY = 3'h1,
    ACS_MODE_CBC = 3'h2
  } acs_mode_type;
  typedef enum logic [1:0] {
    ACS_IDLE = 2'b01,
    ACS_BUSY = 2'b10
  } acs_state_type;
endpackage

/* File: sim/acs_host_model.sv */
// host side model driving byte accesses into the control block
`timescale 1ns/1ps
module acs_host_model (
  input  wire logic       clk_in,    // core clock
  input  wire logic [7:0] rdata_in,  // read data
  output logic            wr_out,    // write strobe
  output logic            rd_out,    // read strobe
  output logic      [7:0] addr_out,  // address
  output logic      [7:0] wdata_out, // write data
  output logic            end_out    // burst end pulse
);
  initial begin
    {wr_out, rd_out, end_out, addr_out, wdata_out} = '0;
  end
  // released bus shows the inverse so stale values never match
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    {wr_out, addr_out, wdata_out} <= {1'b1, a, d};
    @(posedge clk_in);
    {wr_out, addr_out, wdata_out} <= {1'b0, ~a, ~d};
  endtask
  task automatic get(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    {rd_out, addr_out} <= {1'b1, a};
    @(posedge clk_in);
    {rd_out, addr_out} <= {1'b0, ~a};
    #1 d = rdata_in;
  endtask
  task automatic close;
    @(posedge clk_in);
    end_out <= 1'b1;
    @(posedge clk_in);
    end_out <= 1'b0;
  endtask
  // config, block, then request at the alias in one burst
  task automatic launch(input logic [2:0] m, input logic dir);
    if (m == 3'h2) dir = 1'b0; // chaining decrypt never asked
    put(8'h83, {1'b0, m, dir, 3'h0});
    for (int i = 0; i < 16; i++) put(8'h84 + i[7:0], i[7:0]);
    put(8'h94, {1'b1, m, dir, 3'h0});
    close();
  endtask
  // polls status only, control stays untouched while busy
  task automatic wait_done(output logic [7:0] s);
    for (int i = 0; i < 20 && s[0] !== 1'b1; i++) get(8'h82, s);
  endtask
endmodule // acs_host_model

/* File: sim/tb_aes_control_status.sv */
// self-checking bench for the cipher control block
`timescale 1ns/1ps
module tb_aes_control_status;
  import acs_pkg::*;
  logic       clk, rst_b, sleep, wr, rd, endb, start, dec, abort, key;
  logic [7:0] addr, wdata, rdata, s;
  logic [2:0] mode;
  int         bad_count, checks, starts, aborts;
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (start === 1'b1) starts++;
    if (abort === 1'b1) aborts++;
  end
  acs_control #(.RUN_CYCLES(8)) DUT (.core_clk_in(clk), .rst_b_in(rst_b), .sleep_in(sleep),
    .sram_wr_in(wr), .sram_rd_in(rd), .sram_addr_in(addr), .sram_wdata_in(wdata),
    .burst_end_in(endb), .sram_rdata_out(rdata), .core_start_out(start),
    .core_mode_out(mode), .core_decrypt_out(dec), .core_abort_out(abort),
    .key_select_out(key));
  acs_host_model host (.clk_in(clk), .rdata_in(rdata), .wr_out(wr), .rd_out(rd),
    .addr_out(addr), .wdata_out(wdata), .end_out(endb));
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic t_reset;
    logic [7:0] a[4] = '{8'h83, 8'h94, 8'h82, 8'h95};
    foreach (a[i]) begin
      host.get(a[i], s);
      chk("reset read", 8'h00, s);
    end
    $display("test reset done");
  endtask
  task automatic t_modes;
    int n;
    for (int k = 0; k < 6; k++) begin
      n = starts;
      host.launch(k[2:0] >> 1, k[0]);
      chk("start count", 8'(n + 1), 8'(starts));
      chk("mode", {5'h00, k[2:0] >> 1}, {5'h00, mode});
      chk("key select", {7'h00, k < 4 && k > 1}, {7'h00, key});
      chk("decrypt", {7'h00, k[0] && k < 4}, {7'h00, dec});
      host.get(8'h82, s);
      chk("busy status", 8'h00, s);
      host.wait_done(s);
      chk("done status", 8'h01, s);
      host.get(k[0] ? 8'h94 : 8'h83, s);
      chk("ctrl read", {2'b00, k[2:1], k[0] && k < 4, 3'h0}, s);
    end
    $display("test modes done");
  endtask
  task automatic t_abort;
    int n;
    host.launch(3'h0, 1'b0);
    n = aborts;
    host.put(8'h83, 8'h00);
    @(posedge clk);
    #1 chk("abort count", 8'(n + 1), 8'(aborts));
    host.get(8'h82, s);
    chk("abort error", 8'h80, s & 8'h80);
    @(posedge clk) sleep <= 1'b1;
    @(posedge clk) sleep <= 1'b0;
    host.get(8'h82, s);
    chk("sleep status", 8'h00, s);
    host.get(8'h83, s);
    chk("sleep ctrl", 8'h00, s);
    $display("test abort and sleep done");
  endtask
  task automatic t_short;
    repeat (3) host.get(8'h84, s);
    host.close();
    host.get(8'h82, s);
    chk("short read error", 8'h80, s & 8'h80);
    $display("test short readback done");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    {rst_b, sleep} = 2'b00;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_modes();
    t_abort();
    t_short();
    summarize();
  end
  initial begin
    #50000;
    bad_count++;
    summarize();
  end
endmodule // tb_aes_control_status

/* File: src/acs_control.sv */
// cipher control and status registers with run timer
//
// Overview of operation
// [R1] done status bit reads 0 until operation finishes, then 1.
// [R2] any control register access during a run aborts it; host waits for done.
// [R3] write with request bit 7 set starts a run using stored mode and direction.
// [R4] mode bits 6:4: 0 codebook, 1 key load, 2 chaining; 3 to 7 reserved.
// [R5] direction bit 3: 0 encrypt, 1 decrypt; chaining decrypt not allowed.
// [R6] alias address 0x94 behaves exactly like control register 0x83.
// [R7] host ends a write burst at the alias with request set to launch.
// [R8] error set on control access during a run or short block readback.
// [R9] a run not ended early by abort or sleep finishes and raises done 24 us after start.
// [R10] all registers return to reset values on sleep entry; the code leaves rdata_reg at its last read value.
// [R11] block region 0x84..0x93 holds key in mode 1, data otherwise.
// [R12] done clears when a request starts a run and stays clear until it ends.
`timescale 1ns/1ps
`include "acs_defs.svh"
module acs_control
  import acs_pkg::*;
#(
  parameter int RUN_CYCLES = `ACS_RUN_CYCLES
) (
  input  wire logic       core_clk_in,      // 200 MHz core clock
  input  wire logic       rst_b_in,         // async reset, active low
  input  wire logic       sleep_in,         // sleep entry, synchronous clear
  input  wire logic       sram_wr_in,       // one-cycle write strobe
  input  wire logic       sram_rd_in,       // one-cycle read strobe
  input  wire logic [7:0] sram_addr_in,     // sram address
  input  wire logic [7:0] sram_wdata_in,    // write data
  input  wire logic       burst_end_in,     // pulse when access burst closes
  output logic      [7:0] sram_rdata_out,   // read data, valid cycle after strobe
  output logic            core_start_out,   // one-cycle run start pulse
  output logic      [2:0] core_mode_out,    // stored mode
  output logic            core_decrypt_out, // stored direction
  output logic            core_abort_out,   // one-cycle abort pulse
  output logic            key_select_out    // block region holds key
);
  function automatic logic is_ctrl(input logic [7:0] a);
    return (a == `ACS_ADDR_CTRL) || (a == `ACS_ADDR_ALIAS);
  endfunction
  function automatic logic is_block(input logic [7:0] a);
    return (a >= `ACS_ADDR_BLOCK_LO) && (a <= `ACS_ADDR_BLOCK_HI);
  endfunction

  acs_state_type state_reg, state_next;
  logic [2:0]  mode_reg, mode_next;
  logic        dir_reg, dir_next;
  logic        done_reg, done_next;
  logic        err_reg, err_next;
  logic [31:0] cnt_reg, cnt_next;
  logic [4:0]  rdcnt_reg, rdcnt_next;
  logic [7:0]  rdata_reg, rdata_next;
  logic        start_reg, start_next;
  logic        abort_reg, abort_next;
  logic        key_reg, key_next;
  logic        ctrl_hit;
  logic        req_wr;

  always_comb begin
    ctrl_hit   = (sram_wr_in || sram_rd_in) && is_ctrl(sram_addr_in);
    req_wr     = sram_wr_in && is_ctrl(sram_addr_in) && sram_wdata_in[`ACS_BIT_REQUEST];
    state_next = state_reg;
    mode_next  = mode_reg;
    dir_next   = dir_reg;
    done_next  = done_reg;
    err_next   = err_reg;
    cnt_next   = cnt_reg;
    rdcnt_next = rdcnt_reg;
    rdata_next = rdata_reg;
    start_next = 1'b0;
    abort_next = 1'b0;
    if (sram_wr_in && is_ctrl(sram_addr_in)) begin // [R6]
      mode_next = sram_wdata_in[`ACS_MODE_HI:`ACS_MODE_LO]; // [R4]
      dir_next  = sram_wdata_in[`ACS_BIT_DIR]; // [R5]
    end
    if (sram_rd_in) begin
      if (sram_addr_in == `ACS_ADDR_STATUS) begin
        rdata_next = 8'h00;
        rdata_next[`ACS_BIT_ERROR] = err_reg; // [R8]
        rdata_next[`ACS_BIT_DONE]  = done_reg; // [R1]
      end else if (is_ctrl(sram_addr_in)) begin
        // request bit is write-only and reads as zero
        rdata_next = {1'b0, mode_reg, dir_reg, 3'h0};
      end else begin
        rdata_next = 8'h00;
      end
    end
    if (sram_rd_in && is_block(sram_addr_in) && rdcnt_reg != 5'(`ACS_BLOCK_BYTES)) begin
      rdcnt_next = rdcnt_reg + 5'h01;
    end
    // a partly read result block counts as an error once the burst closes
    if (burst_end_in) begin
      if (rdcnt_reg != 5'h00 && rdcnt_reg != 5'(`ACS_BLOCK_BYTES)) begin
        err_next = 1'b1; // [R8]
      end
      rdcnt_next = 5'h00;
    end
    case (state_reg)
      ACS_IDLE: begin
        if (req_wr) begin // [R3]
          state_next = ACS_BUSY;
          start_next = 1'b1;
          done_next  = 1'b0; // [R12]
          cnt_next   = 32'h0;
        end
      end
      ACS_BUSY: begin
        if (ctrl_hit) begin // [R2]
          state_next = ACS_IDLE;
          abort_next = 1'b1;
          err_next   = 1'b1; // [R8]
        end else if (cnt_reg == 32'(RUN_CYCLES - 1)) begin // [R9]
          state_next = ACS_IDLE;
          done_next  = 1'b1; // [R1]
        end else begin
          cnt_next = cnt_reg + 32'h1;
        end
      end
      default: state_next = ACS_IDLE;
    endcase
    if (sleep_in) begin // [R10]
      state_next = ACS_IDLE;
      mode_next  = 3'(`ACS_CTRL_RESET >> `ACS_MODE_LO);
      dir_next   = 1'b0;
      done_next  = 1'b0;
      err_next   = 1'b0;
      cnt_next   = 32'h0;
      rdcnt_next = 5'h00;
      start_next = 1'b0;
      abort_next = 1'b0;
    end
    // registered from the next mode so the select line never glitches
    // and always matches the stored mode, sleep included
    key_next   = (mode_next == ACS_MODE_KEY); // [R11]
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg <= ACS_IDLE;
      mode_reg  <= 3'h0;
      dir_reg   <= 1'b0;
      done_reg  <= 1'b0;
      err_reg   <= 1'b0;
      cnt_reg   <= 32'h0;
      rdcnt_reg <= 5'h00;
      rdata_reg <= 8'h00;
      start_reg <= 1'b0;
      abort_reg <= 1'b0;
      key_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      mode_reg  <= mode_next;
      dir_reg   <= dir_next;
      done_reg  <= done_next;
      err_reg   <= err_next;
      cnt_reg   <= cnt_next;
      rdcnt_reg <= rdcnt_next;
      rdata_reg <= rdata_next;
      start_reg <= start_next;
      abort_reg <= abort_next;
      key_reg   <= key_next;
    end
  end

  assign sram_rdata_out   = rdata_reg;
  assign core_start_out   = start_reg;
  assign core_mode_out    = mode_reg;
  assign core_decrypt_out = dir_reg;
  assign core_abort_out   = abort_reg;
  assign key_select_out   = key_reg; // [R11]

  a_start_clears_done: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [R12]
    (state_reg == ACS_IDLE && req_wr && !sleep_in) |=> (!done_reg && state_reg == ACS_BUSY))
    else $error("done not cleared on start");
  a_run_length: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [R9]
    (state_reg == ACS_BUSY && cnt_reg == 32'(RUN_CYCLES - 1) && !ctrl_hit && !sleep_in)
      |=> done_reg)
    else $error("done not raised at end of run");
  a_done_low_busy: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [R1]
    (state_reg == ACS_BUSY) |-> !done_reg)
    else $error("done high while busy");
  a_abort_on_access: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [R2]
    (state_reg == ACS_BUSY && ctrl_hit && !sleep_in)
      |=> (state_reg == ACS_IDLE && core_abort_out && err_reg))
    else $error("control access did not abort");
  a_start_pulse: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [R3]
    core_start_out |-> ($past(req_wr) && state_reg == ACS_BUSY && cnt_reg == 32'h0))
    else $error("start pulse without request");
  a_alias_mode: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [R6]
    (sram_wr_in && sram_addr_in == `ACS_ADDR_ALIAS && !sleep_in)
      |=> (mode_reg == $past(sram_wdata_in[6:4]) && dir_reg == $past(sram_wdata_in[3])))
    else $error("alias write not stored");
  a_sleep_clears: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [R10]
    sleep_in |=> (state_reg == ACS_IDLE && !done_reg && !err_reg && mode_reg == 3'h0))
    else $error("sleep did not reset registers");
  a_key_select: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [R11]
    key_select_out == (mode_reg == 3'h1))
    else $error("key select mismatch");
  // sleep masks the next three checks since it clears every register but rdata_reg at once
  a_short_read_err: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [R8]
    (burst_end_in && rdcnt_reg != 5'h00 && rdcnt_reg != 5'(`ACS_BLOCK_BYTES) && !sleep_in)
      |=> err_reg)
    else $error("short readback did not set error");
  a_error_sticky: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [R8]
    (err_reg && !sleep_in) |=> err_reg)
    else $error("error flag lost without sleep");
  a_mode_stored: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [R4]
    (sram_wr_in && sram_addr_in == `ACS_ADDR_CTRL && !sleep_in)
      |=> (core_mode_out == $past(sram_wdata_in[6:4])
           && core_decrypt_out == $past(sram_wdata_in[3])))
    else $error("control write not stored");
  a_status_read: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [R1]
    (sram_rd_in && sram_addr_in == `ACS_ADDR_STATUS)
      |=> (sram_rdata_out == {$past(err_reg), 6'h00, $past(done_reg)}))
    else $error("status read wrong");
  a_busy_no_start: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [R2]
    (state_reg == ACS_BUSY) |=> !core_start_out)
    else $error("start pulse from a busy state");
  a_abort_one_pulse: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [R2]
    core_abort_out |=> !core_abort_out)
    else $error("abort pulse longer than one cycle");
endmodule // acs_control
